// >>> pkg/ddsl_regs.svh
// constants of the serial register loader
`ifndef DDSL_REGS_SVH
`define DDSL_REGS_SVH
`define DDSL_FRAME_BITS 5'd16
`define DDSL_CMD_MSB 15
`define DDSL_CMD_LSB 12
`define DDSL_ADR_MSB 11
`define DDSL_ADR_LSB 8
`define DDSL_SYNC_BIT 13
`define DDSL_SRC_BIT 12
`define DDSL_SLEEP_BIT 13
`define DDSL_RESET_BIT 12
`define DDSL_CLR_BIT 11
`define DDSL_PSEL_LO_BIT 9
`define DDSL_PSEL_HI_BIT 10
`define DDSL_FSEL_BIT 11
`define DDSL_SYNC_STAGES 2
`define DDSL_RST_TUNING 32'h0000_0000
`define DDSL_RST_HALF 16'h0000
`define DDSL_RST_OFFSET 12'h000
`define DDSL_RST_DEFER 16'h0000
`endif

// >>> pkg/ddsl_pkg.sv
// types of the serial register loader
package ddsl_pkg;
  typedef enum logic [3:0] {
    DDSL_CMD_PH16 = 4'h0,
    DDSL_CMD_PH8 = 4'h1,
    DDSL_CMD_FR16 = 4'h2,
    DDSL_CMD_FR8 = 4'h3,
    DDSL_CMD_PSEL = 4'h4,
    DDSL_CMD_FSEL = 4'h5,
    DDSL_CMD_ASEL = 4'h6,
    DDSL_CMD_TEST = 4'h7
  } ddsl_cmd_t;
  typedef enum logic [2:0] {
    DDSL_IDLE = 3'b001,
    DDSL_SHIFT = 3'b010,
    DDSL_WAIT = 3'b100
  } ddsl_state_t;
endpackage : ddsl_pkg

// >>> core/ddsl_loader.sv
// serial word decoder loading tuning and offset registers
// Summary of operation
// - two 32-bit tuning words, selector picks one
// - four 12-bit offsets picked by two selects
// - tuning halves load independently
// - deferred byte only fills defer half
// - direct byte fills half, then loads destination
// - defer register keeps last loaded word
// - source bit picks pins or internal selects
// - clear zeroes sync and source, self-clears
// - transfers only after sixteenth falling edge
// - control word 10 sets sync, source
// - sync aligns loading, adds two cycles
// - control word 11 bit13 sleeps device
// - reset bit holds accumulator at zero
// - destination loads on following clock edge
// - sync adds two core-clock rising-edge pipeline stages
// - sync samples select pins after settling
// - frame low, sixteen bits on falling edges
// - commands 0-3 load phase/frequency data
// - commands 4-6 set internal select bits
// - select latency three or five cycles
`timescale 1ns/1ps
`include "ddsl_regs.svh"
module ddsl_loader (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // serial port pins
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic frame_sync_n,
  // select pins
  input wire logic tuning_selector,
  input wire logic offset_selector_lo,
  input wire logic offset_selector_hi,
  // loaded registers
  output logic [31:0] tuning_word_a,
  output logic [31:0] tuning_word_b,
  output logic [11:0] offset_word_a,
  output logic [11:0] offset_word_b,
  output logic [11:0] offset_word_c,
  output logic [11:0] offset_word_d,
  // active selection and control
  output logic [31:0] active_tuning,
  output logic [11:0] active_offset,
  output logic sync_enable,
  output logic selection_source_bit,
  output logic sleep_mode,
  output logic accum_reset
);
  // pin synchronisers; first stage read only by second
  logic [2:0] s1_ff, s2_ff, nxt_s1, nxt_s2;
  logic [2:0] p1_ff, p2_ff, nxt_p1, nxt_p2;
  logic sclk_d_ff, nxt_sclk_d;
  always_comb begin
    nxt_s1 = {serial_clk, serial_data_in, frame_sync_n};
    nxt_s2 = s1_ff;
    nxt_p1 = {tuning_selector, offset_selector_hi, offset_selector_lo};
    nxt_p2 = p1_ff;
    nxt_sclk_d = s2_ff[2];
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= 3'b101;
      s2_ff <= 3'b101;
      p1_ff <= 3'b000;
      p2_ff <= 3'b000;
      sclk_d_ff <= 1'b1;
    end else if (clk_en) begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      p1_ff <= nxt_p1;
      p2_ff <= nxt_p2;
      sclk_d_ff <= nxt_sclk_d;
    end
  end
  logic sclk_fall, fs_n, sdi;
  assign sclk_fall = sclk_d_ff & ~s2_ff[2];
  assign sdi = s2_ff[1];
  assign fs_n = s2_ff[0];
  // frame shifter
  ddsl_pkg::ddsl_state_t st_ff, nxt_st;
  logic [15:0] shift_ff, nxt_shift;
  logic [4:0] cnt_ff, nxt_cnt;
  logic word_ok;
  always_comb begin
    nxt_st = st_ff;
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    word_ok = 1'b0;
    unique case (st_ff)
      ddsl_pkg::DDSL_IDLE: begin
        nxt_cnt = 5'd0;
        if (!fs_n) nxt_st = ddsl_pkg::DDSL_SHIFT;
      end
      ddsl_pkg::DDSL_SHIFT: begin
        if (fs_n) begin
          nxt_st = ddsl_pkg::DDSL_IDLE;
        end else if (sclk_fall) begin
          nxt_shift = {shift_ff[14:0], sdi};
          nxt_cnt = cnt_ff + 5'd1;
          if (cnt_ff + 5'd1 == `DDSL_FRAME_BITS) begin
            word_ok = 1'b1;
            nxt_st = ddsl_pkg::DDSL_WAIT;
          end
        end
      end
      ddsl_pkg::DDSL_WAIT: begin
        if (fs_n) nxt_st = ddsl_pkg::DDSL_IDLE;
      end
      default: nxt_st = ddsl_pkg::DDSL_IDLE;
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= ddsl_pkg::DDSL_IDLE;
      shift_ff <= 16'h0000;
      cnt_ff <= 5'd0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      shift_ff <= nxt_shift;
      cnt_ff <= nxt_cnt;
    end
  end
  logic [15:0] word;
  assign word = {shift_ff[14:0], sdi};
  // decode into defer, data and select registers
  logic [15:0] defer_ff, nxt_defer, data_ff, nxt_data;
  logic [3:0] dadr_ff, nxt_dadr;
  logic dload_ff, nxt_dload, selld_ff, nxt_selld;
  logic [2:0] selb_ff, nxt_selb;
  logic sync_ff, nxt_sync, src_ff, nxt_src;
  logic sleep_ff, nxt_sleep, ares_ff, nxt_ares;
  ddsl_pkg::ddsl_cmd_t cmd;
  logic [3:0] adr;
  assign cmd = ddsl_pkg::ddsl_cmd_t'(word[`DDSL_CMD_MSB:`DDSL_CMD_LSB]);
  assign adr = word[`DDSL_ADR_MSB:`DDSL_ADR_LSB];
  always_comb begin
    nxt_defer = defer_ff;
    nxt_data = data_ff;
    nxt_dadr = dadr_ff;
    nxt_dload = 1'b0;
    nxt_selld = 1'b0;
    nxt_selb = selb_ff;
    nxt_sync = sync_ff;
    nxt_src = src_ff;
    nxt_sleep = sleep_ff;
    nxt_ares = ares_ff;
    if (word_ok) begin
      if (word[15]) begin
        if (!word[14]) begin
          nxt_sync = word[`DDSL_SYNC_BIT];
          nxt_src = word[`DDSL_SRC_BIT];
        end else begin
          nxt_sleep = word[`DDSL_SLEEP_BIT];
          nxt_ares = word[`DDSL_RESET_BIT];
          if (word[`DDSL_CLR_BIT]) begin // pulse, not stored
            nxt_sync = 1'b0;
            nxt_src = 1'b0;
          end
        end
      end else if (!word[14]) begin
        if (adr[0]) nxt_defer[15:8] = word[7:0];
        else nxt_defer[7:0] = word[7:0];
        if (!word[12]) begin
          nxt_data = nxt_defer;
          nxt_dadr = adr;
          nxt_dload = 1'b1;
        end
      end else begin
        unique case (cmd)
          ddsl_pkg::DDSL_CMD_PSEL: begin
            nxt_selb[1:0] = word[`DDSL_PSEL_HI_BIT:`DDSL_PSEL_LO_BIT];
            nxt_selld = 1'b1;
          end
          ddsl_pkg::DDSL_CMD_FSEL: begin
            nxt_selb[2] = word[`DDSL_FSEL_BIT];
            nxt_selld = 1'b1;
          end
          ddsl_pkg::DDSL_CMD_ASEL: begin
            nxt_selb = word[`DDSL_FSEL_BIT:`DDSL_PSEL_LO_BIT];
            nxt_selld = 1'b1;
          end
          default: nxt_selld = 1'b0; // test code ignored
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      defer_ff <= `DDSL_RST_DEFER;
      data_ff <= `DDSL_RST_DEFER;
      dadr_ff <= 4'h0;
      dload_ff <= 1'b0;
      selld_ff <= 1'b0;
      selb_ff <= 3'b000;
      sync_ff <= 1'b0;
      src_ff <= 1'b0;
      sleep_ff <= 1'b0;
      ares_ff <= 1'b0;
    end else if (clk_en) begin
      defer_ff <= nxt_defer;
      data_ff <= nxt_data;
      dadr_ff <= nxt_dadr;
      dload_ff <= nxt_dload;
      selld_ff <= nxt_selld;
      selb_ff <= nxt_selb;
      sync_ff <= nxt_sync;
      src_ff <= nxt_src;
      sleep_ff <= nxt_sleep;
      ares_ff <= nxt_ares;
    end
  end
  logic [`DDSL_SYNC_STAGES-1:0] dpipe_ff, nxt_dpipe, spipe_ff, nxt_spipe;
  logic [2:0] pin_q1_ff, pin_q2_ff, nxt_pq1, nxt_pq2;
  logic do_load, do_sel;
  logic [2:0] pins_used;
  always_comb begin
    nxt_dpipe = {dpipe_ff[0], dload_ff};
    nxt_spipe = {spipe_ff[0], selld_ff};
    nxt_pq1 = p2_ff;
    nxt_pq2 = pin_q1_ff;
    do_load = sync_ff ? dpipe_ff[1] : dload_ff;
    do_sel = sync_ff ? spipe_ff[1] : selld_ff;
    pins_used = sync_ff ? pin_q2_ff : p2_ff;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dpipe_ff <= '0;
      spipe_ff <= '0;
      pin_q1_ff <= 3'b000;
      pin_q2_ff <= 3'b000;
    end else if (clk_en) begin
      dpipe_ff <= nxt_dpipe;
      spipe_ff <= nxt_spipe;
      pin_q1_ff <= nxt_pq1;
      pin_q2_ff <= nxt_pq2;
    end
  end
  logic [15:0] tah_ff, tal_ff, tbh_ff, tbl_ff;
  logic [15:0] nxt_tah, nxt_tal, nxt_tbh, nxt_tbl;
  logic [11:0] ofs_ff [4];
  logic [11:0] nxt_ofs [4];
  logic [2:0] selreg_ff, nxt_selreg, sel_eff;
  logic [31:0] nxt_act_t;
  logic [11:0] nxt_act_o;
  always_comb begin
    nxt_tah = tah_ff;
    nxt_tal = tal_ff;
    nxt_tbh = tbh_ff;
    nxt_tbl = tbl_ff;
    nxt_ofs = ofs_ff;
    nxt_selreg = do_sel ? selb_ff : selreg_ff;
    if (do_load) begin
      unique case (dadr_ff[3:1]) // halves apart
        3'd0: nxt_tal = data_ff;
        3'd1: nxt_tah = data_ff;
        3'd2: nxt_tbl = data_ff;
        3'd3: nxt_tbh = data_ff;
        default: nxt_ofs[dadr_ff[2:1]] = data_ff[11:0];
      endcase
    end
    sel_eff = src_ff ? selreg_ff : pins_used;
    nxt_act_t = sel_eff[2] ? {tbh_ff, tbl_ff} : {tah_ff, tal_ff};
    nxt_act_o = ofs_ff[sel_eff[1:0]];
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tah_ff <= `DDSL_RST_HALF;
      tal_ff <= `DDSL_RST_HALF;
      tbh_ff <= `DDSL_RST_HALF;
      tbl_ff <= `DDSL_RST_HALF;
      for (int i = 0; i < 4; i++) ofs_ff[i] <= `DDSL_RST_OFFSET;
      selreg_ff <= 3'b000;
      active_tuning <= `DDSL_RST_TUNING;
      active_offset <= `DDSL_RST_OFFSET;
    end else if (clk_en) begin
      tah_ff <= nxt_tah;
      tal_ff <= nxt_tal;
      tbh_ff <= nxt_tbh;
      tbl_ff <= nxt_tbl;
      ofs_ff <= nxt_ofs;
      selreg_ff <= nxt_selreg;
      active_tuning <= nxt_act_t;
      active_offset <= nxt_act_o;
    end
  end
  assign tuning_word_a = {tah_ff, tal_ff};
  assign tuning_word_b = {tbh_ff, tbl_ff};
  assign offset_word_a = ofs_ff[0];
  assign offset_word_b = ofs_ff[1];
  assign offset_word_c = ofs_ff[2];
  assign offset_word_d = ofs_ff[3];
  assign sync_enable = sync_ff;
  assign selection_source_bit = src_ff;
  assign sleep_mode = sleep_ff;
  assign accum_reset = ares_ff;
  // a load strobe lands the data word in the addressed tuning half
  property p_load_lat;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && do_load && !dadr_ff[3]) |=>
        16'({tuning_word_b, tuning_word_a} >> (16 * dadr_ff[2:1])) == data_ff;
  endproperty
  a_load_lat: assert property (p_load_lat) else $error("late load");
  property p_sync_lat;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && dload_ff && sync_ff) ##1 clk_en ##1 clk_en |-> do_load;
  endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("sync delay");
  property p_defer_keep;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && dload_ff) |-> data_ff == defer_ff;
  endproperty
  a_defer_keep: assert property (p_defer_keep) else $error("defer lost");
  property p_only16;
    @(posedge core_clk) disable iff (!rstn)
      word_ok |-> cnt_ff == 5'd15;
  endproperty
  a_only16: assert property (p_only16) else $error("short frame");
  property p_src_sel;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && src_ff && !do_sel && !do_load) |=>
        (!clk_en || active_tuning == (selreg_ff[2] ? tuning_word_b
                                                   : tuning_word_a));
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("bad select");
  property p_clear;
    @(posedge core_clk) disable iff (!rstn)
      (clk_en && word_ok && word[15:14] == 2'b11 && word[`DDSL_CLR_BIT]) |=>
        (!sync_ff && !src_ff);
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");
endmodule : ddsl_loader

// >>> verification/ddsl_host_model.sv
// host model driving framed serial words into the loader
`timescale 1ns/1ps
module ddsl_host_model (
  // serial pins
  output logic serial_clk,
  output logic serial_data_in,
  output logic frame_sync_n
);
  // clock idles high and stands still between frames
  initial begin
    serial_clk = 1'b1;
    serial_data_in = 1'b0;
    frame_sync_n = 1'b1;
  end
  // msb first, one bit per falling edge; n below 16 aborts the frame
  task automatic send(input logic [15:0] w, input int n);
    frame_sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_data_in = w[15 - i];
      #32 serial_clk = 1'b0;
      #32 serial_clk = 1'b1;
    end
    frame_sync_n = 1'b1;
    // released line must not keep its last value
    serial_data_in = ~serial_data_in;
  endtask : send
endmodule : ddsl_host_model

// >>> verification/tb_ddsl_loader.sv
// self-checking bench of the serial register loader
`timescale 1ns/1ps
module tb_ddsl_loader;
  logic core_clk, rstn, clk_en, sclk, sdi, fsn, fsel, plo, phi;
  logic [31:0] tw_a, tw_b, act_t;
  logic [11:0] ow_a, ow_b, ow_c, ow_d, act_o;
  logic sync_o, src_o, sleep_o, ar_o;
  int fails = 0;
  int check_count = 0;
  // reference model state
  logic [31:0] m_tw [2] = '{32'h0000_0000, 32'h0000_0000};
  logic [11:0] m_ow [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
  logic [15:0] m_def = 16'h0000;
  logic m_sync = 0, m_src = 0, m_slp = 0, m_ar = 0;
  logic m_fs = 0, m_plo = 0, m_phi = 0;
  logic [15:0] v;
  logic [3:0] c;

  ddsl_loader u_ddsl_loader (.core_clk(core_clk), .rstn(rstn),
    .clk_en(clk_en), .serial_clk(sclk), .serial_data_in(sdi),
    .frame_sync_n(fsn), .tuning_selector(fsel),
    .offset_selector_lo(plo), .offset_selector_hi(phi),
    .tuning_word_a(tw_a), .tuning_word_b(tw_b), .offset_word_a(ow_a),
    .offset_word_b(ow_b), .offset_word_c(ow_c), .offset_word_d(ow_d),
    .active_tuning(act_t), .active_offset(act_o), .sync_enable(sync_o),
    .selection_source_bit(src_o), .sleep_mode(sleep_o),
    .accum_reset(ar_o));
  ddsl_host_model u_ddsl_host_model (.serial_clk(sclk),
    .serial_data_in(sdi), .frame_sync_n(fsn));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cmp();
    logic fi;
    logic [1:0] pi;
    fi = m_src ? m_fs : fsel;
    pi = m_src ? {m_phi, m_plo} : {phi, plo};
    chk("tw_a", m_tw[0], tw_a);
    chk("tw_b", m_tw[1], tw_b);
    chk("ow_a", {20'h0_0000, m_ow[0]}, {20'h0_0000, ow_a});
    chk("ow_b", {20'h0_0000, m_ow[1]}, {20'h0_0000, ow_b});
    chk("ow_c", {20'h0_0000, m_ow[2]}, {20'h0_0000, ow_c});
    chk("ow_d", {20'h0_0000, m_ow[3]}, {20'h0_0000, ow_d});
    chk("act_t", m_tw[fi], act_t);
    chk("act_o", {20'h0_0000, m_ow[pi]}, {20'h0_0000, act_o});
    chk("sync", {31'h0, m_sync}, {31'h0, sync_o});
    chk("src", {31'h0, m_src}, {31'h0, src_o});
    chk("sleep", {31'h0, m_slp}, {31'h0, sleep_o});
    chk("areset", {31'h0, m_ar}, {31'h0, ar_o});
  endtask : cmp

  // reference decode of one complete word
  task automatic mdl(input logic [15:0] w);
    logic [2:0] a;
    a = w[11:9];
    if (w[15:14] == 2'b10) begin
      m_sync = w[13];
      m_src = w[12];
    end else if (w[15:14] == 2'b11) begin
      m_slp = w[13];
      m_ar = w[12];
      if (w[11]) {m_sync, m_src} = 2'b00;
    end else if (w[15:12] <= 4'h3) begin
      if (w[8]) m_def[15:8] = w[7:0];
      else m_def[7:0] = w[7:0];
      if (!w[12] && a < 3'h4) begin
        if (a[0]) m_tw[a[1]][31:16] = m_def;
        else m_tw[a[1]][15:0] = m_def;
      end else if (!w[12]) m_ow[a[1:0]] = m_def[11:0];
    end else if (w[15:12] != 4'h7) begin
      if (w[15:12] != 4'h5) {m_phi, m_plo} = w[10:9];
      if (w[15:12] != 4'h4) m_fs = w[11];
    end
  endtask : mdl

  // one frame with fresh random select pins, then compare
  task automatic wr(input logic [15:0] w, input int n = 16);
    @(posedge core_clk);
    #1 {fsel, plo, phi} = 3'($urandom);
    if (n == 16) mdl(w);
    u_ddsl_host_model.send(w, n);
    repeat (12) @(posedge core_clk);
    #1 cmp();
  endtask : wr

  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    results();
  end

  initial begin
    rstn = 1'b0;
    clk_en = 1'b1;
    {fsel, plo, phi} = 3'h0;
    void'($urandom(32'hc7fc_4c2d));
    repeat (20) @(posedge core_clk);
    #1 cmp();
    rstn = 1'b1;
    repeat (4) @(posedge core_clk);
    for (int s = 0; s < 2; s++) begin
      if (s == 1) wr(16'ha000);
      for (int k = 0; k < 8; k++) begin
        v = 16'($urandom);
        c = (k > 3) ? 4'h0 : 4'h2;
        if (k > 3) v[15:12] = 4'h0;
        wr({c + 4'h1, 3'(k), 1'b1, v[15:8]});
        wr({c, 3'(k), 1'b0, v[7:0]});
      end
    end
    wr({4'h0, 4'he, 8'($urandom)});
    wr(16'h31ff);
    wr(16'h2000, 8);
    wr(16'h7fff);
    wr(16'h9000);
    wr(16'h4600);
    wr(16'h5800);
    wr(16'h6200);
    for (int j = 0; j < 6; j++) wr({4'(4 + j % 3), 12'($urandom)});
    wr(16'hb000);
    wr(16'h6c00);
    wr(16'he800);
    wr(16'hd000);
    wr(16'hc000);
    for (int j = 0; j < 4; j++) wr({4'h4, 12'($urandom)});
    results();
  end
endmodule : tb_ddsl_loader
